// [hw/haptic_cfg_pkg.sv]
// constants for the haptic actuator calibration and configuration registers
package haptic_cfg_pkg;
   // register offsets on the byte-wide register port
   localparam logic [7:0] ADDR_CURRENT_LIMIT = 8'h0E;
   localparam logic [7:0] ADDR_SCALE_HIGH = 8'h0F;
   localparam logic [7:0] ADDR_SCALE_LOW = 8'h10;
   localparam logic [7:0] ADDR_IMP_HIGH = 8'h11;
   localparam logic [7:0] ADDR_IMP_LOW = 8'h12;
   localparam logic [7:0] ADDR_TOP_CFG = 8'h13;

   // reset values
   localparam logic [4:0] RST_CURRENT_CODE = 5'h17;
   localparam logic [7:0] RST_SCALE_HIGH = 8'h01;
   localparam logic [7:0] RST_SCALE_LOW = 8'h0D;
   localparam logic [9:0] RST_IMPEDANCE = 10'h000;
   localparam logic [7:0] RST_TOP_CFG = 8'h1E;
   localparam logic [7:0] RST_RDATA = 8'h00;
   localparam logic [7:0] RST_RATING = 8'h00;

   // top configuration field positions
   localparam int BIT_EMBEDDED = 7;
   localparam int BIT_ERM_TYPE = 5;
   localparam int BIT_LOOP_COMPUTE = 4;
   localparam int BIT_FREQ_TRACK = 3;
   localparam int BIT_ACCEL = 2;
   localparam int BIT_RAPID_STOP = 1;
   localparam int BIT_AMP_LOOP = 0;
   // implemented bits of the top configuration byte (bit 6 unused)
   localparam logic [7:0] TOP_CFG_MASK = 8'hBF;

   // field widths
   localparam int CURRENT_CODE_W = 5;
   localparam int IMP_W = 10;
   localparam int IMP_LOW_W = 2;
   localparam int BYTE_W = 8;

   // host-side scaling figures, kept for reference by firmware models
   localparam real CURRENT_OFFSET_MA = 28.6;
   localparam real CURRENT_STEP_MA = 7.2;
   localparam real SCALE_DIVISOR = 1.6104;
   localparam int SCALE_CODE_OFFSET = 4;
   localparam real IMP_LSB_MILLIOHM = 62.5;
endpackage : haptic_cfg_pkg

// [hw/full_scale_select.sv]
// full-scale and overdrive limit selection from the voltage ratings
`timescale 1ns/1ps
module full_scale_select
(
   input wire logic ref_clk, // register clock
   input wire logic sys_rst, // synchronous reset, active high
   input wire logic clk_en, // freezes state while low
   input wire logic accel_en, // active acceleration enable
   input wire logic [7:0] nominal_rating, // nominal voltage rating code
   input wire logic [7:0] abs_max_rating, // absolute maximum rating code
   output logic [7:0] full_scale_reg, // full scale of unsigned waveforms
   output logic [7:0] overdrive_limit_reg // ceiling on drive level
);
   // with acceleration the nominal rating is full scale and overdrive
   // may climb to the absolute maximum; without it both are the max
   wire [7:0] full_scale_next = accel_en ? nominal_rating
                                         : abs_max_rating;
   wire [7:0] overdrive_limit_next = abs_max_rating;

   // registered so the drive path sees glitch-free levels
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         full_scale_reg <= haptic_cfg_pkg::RST_RATING;
         overdrive_limit_reg <= haptic_cfg_pkg::RST_RATING;
      end
      else if (clk_en)
      begin
         full_scale_reg <= full_scale_next;
         overdrive_limit_reg <= overdrive_limit_next;
      end
   end
endmodule : full_scale_select

// [hw/haptic_actuator_calib_config_regs.sv]
// calibration and top configuration register bank of the haptic driver
`timescale 1ns/1ps
// Functional notes
// - five-bit max current code, resets to 0x17
// - scale factor is high byte over low
// - read-only ten-bit impedance, 62.5 milliohm units
// - embedded bit selects automatic fault clearing
// - bit 5 picks resonant or rotating actuator
// - bit 4 enables internal loop computations
// - bit 3 tracks frequency, ignored for rotating
// - bit 2 enables active acceleration
// - bit 1 enables rapid stop braking
// - bit 0 enables amplitude loop
// - acceleration picks full scale voltage rating
module haptic_actuator_calib_config_regs
(
   input wire logic ref_clk, // register clock, 10 MHz
   input wire logic sys_rst, // synchronous reset, active high
   input wire logic clk_en, // freezes all state while low
   input wire logic [7:0] reg_addr, // register address from serial port
   input wire logic reg_wr, // write strobe, one cycle
   input wire logic [7:0] reg_wdata, // write data
   input wire logic reg_rd, // read strobe, one cycle
   output logic [7:0] reg_rdata_reg, // read data, one cycle after strobe
   input wire logic imp_load, // measured impedance valid, one cycle
   input wire logic [9:0] imp_value, // measured impedance code
   input wire logic fault_event, // fault condition from the drive logic
   input wire logic fault_clear, // host request to clear the fault
   input wire logic [7:0] nominal_rating, // nominal voltage rating code
   input wire logic [7:0] abs_max_rating, // absolute maximum rating code
   output logic [4:0] max_current_code_reg, // current limit code
   output logic [15:0] drive_scale_reg, // impedance to drive scale
   output logic embedded_mode_reg, // faults cleared automatically
   output logic erm_type_reg, // 1 rotating mass, 0 resonant
   output logic loop_compute_en_reg, // internal loop computations
   output logic freq_track_active_reg, // tracking, gated by type
   output logic accel_en_reg, // active acceleration enable
   output logic rapid_stop_en_reg, // rapid stop braking enable
   output logic amplitude_loop_en_reg, // amplitude loop enable
   output logic fault_flag_reg, // sticky fault flag
   output logic [7:0] full_scale_reg, // waveform full scale
   output logic [7:0] overdrive_limit_reg // overdrive ceiling
);
   // storage
   logic [4:0] current_code_reg; // current limit code
   logic [7:0] scale_high_reg; // scale factor high byte
   logic [7:0] scale_low_reg; // scale factor low byte
   logic [9:0] impedance_reg; // last measured impedance
   logic [7:0] top_cfg_reg; // top configuration byte

   // address decode
   wire sel_current = (reg_addr == haptic_cfg_pkg::ADDR_CURRENT_LIMIT);
   wire sel_scale_h = (reg_addr == haptic_cfg_pkg::ADDR_SCALE_HIGH);
   wire sel_scale_l = (reg_addr == haptic_cfg_pkg::ADDR_SCALE_LOW);
   wire sel_imp_h = (reg_addr == haptic_cfg_pkg::ADDR_IMP_HIGH);
   wire sel_imp_l = (reg_addr == haptic_cfg_pkg::ADDR_IMP_LOW);
   wire sel_top = (reg_addr == haptic_cfg_pkg::ADDR_TOP_CFG);

   // write enables; impedance bytes are read-only so have none
   wire wr_current = reg_wr & sel_current;
   wire wr_scale_h = reg_wr & sel_scale_h;
   wire wr_scale_l = reg_wr & sel_scale_l;
   wire wr_top = reg_wr & sel_top;

   // next values
   wire [4:0] current_code_next = wr_current
      ? reg_wdata[haptic_cfg_pkg::CURRENT_CODE_W-1:0]
      : current_code_reg;
   wire [7:0] scale_high_next = wr_scale_h ? reg_wdata : scale_high_reg;
   wire [7:0] scale_low_next = wr_scale_l ? reg_wdata : scale_low_reg;
   wire [9:0] impedance_next = imp_load ? imp_value : impedance_reg;
   wire [7:0] top_cfg_next = wr_top
      ? (reg_wdata & haptic_cfg_pkg::TOP_CFG_MASK)
      : top_cfg_reg;

   // fields of the configuration value about to take effect
   wire embedded_next = top_cfg_next[haptic_cfg_pkg::BIT_EMBEDDED];
   wire erm_next = top_cfg_next[haptic_cfg_pkg::BIT_ERM_TYPE];
   // tracking only applies to the resonant actuator type
   wire track_next = top_cfg_next[haptic_cfg_pkg::BIT_FREQ_TRACK]
                     & ~erm_next;

   // sticky fault: set wins over any clear in the same cycle; in
   // embedded mode the flag follows the condition and frees itself
   wire fault_flag_next = fault_event
      | (fault_flag_reg & ~embedded_next & ~fault_clear);

   // read data mux; narrow fields sit low, upper bits zero
   wire [7:0] imp_high_byte = impedance_reg[haptic_cfg_pkg::IMP_W-1:
                                            haptic_cfg_pkg::IMP_LOW_W];
   wire [7:0] imp_low_byte = {6'h00,
      impedance_reg[haptic_cfg_pkg::IMP_LOW_W-1:0]};
   wire [7:0] rdata_next =
      sel_current ? {3'h0, current_code_reg} :
      sel_scale_h ? scale_high_reg :
      sel_scale_l ? scale_low_reg :
      sel_imp_h ? imp_high_byte :
      sel_imp_l ? imp_low_byte :
      sel_top ? top_cfg_reg :
      haptic_cfg_pkg::RST_RDATA; // unmapped reads return zero

   // register storage
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         current_code_reg <= haptic_cfg_pkg::RST_CURRENT_CODE;
         scale_high_reg <= haptic_cfg_pkg::RST_SCALE_HIGH;
         scale_low_reg <= haptic_cfg_pkg::RST_SCALE_LOW;
         impedance_reg <= haptic_cfg_pkg::RST_IMPEDANCE;
         top_cfg_reg <= haptic_cfg_pkg::RST_TOP_CFG;
      end
      else if (clk_en)
      begin
         current_code_reg <= current_code_next;
         scale_high_reg <= scale_high_next;
         scale_low_reg <= scale_low_next;
         impedance_reg <= impedance_next;
         top_cfg_reg <= top_cfg_next;
      end
   end

   // outputs toward the drive loops, one flop each
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         max_current_code_reg <= haptic_cfg_pkg::RST_CURRENT_CODE;
         drive_scale_reg <= {haptic_cfg_pkg::RST_SCALE_HIGH,
                             haptic_cfg_pkg::RST_SCALE_LOW};
         embedded_mode_reg <=
            haptic_cfg_pkg::RST_TOP_CFG[haptic_cfg_pkg::BIT_EMBEDDED];
         erm_type_reg <=
            haptic_cfg_pkg::RST_TOP_CFG[haptic_cfg_pkg::BIT_ERM_TYPE];
         loop_compute_en_reg <=
            haptic_cfg_pkg::RST_TOP_CFG[haptic_cfg_pkg::BIT_LOOP_COMPUTE];
         freq_track_active_reg <=
            haptic_cfg_pkg::RST_TOP_CFG[haptic_cfg_pkg::BIT_FREQ_TRACK];
         accel_en_reg <=
            haptic_cfg_pkg::RST_TOP_CFG[haptic_cfg_pkg::BIT_ACCEL];
         rapid_stop_en_reg <=
            haptic_cfg_pkg::RST_TOP_CFG[haptic_cfg_pkg::BIT_RAPID_STOP];
         amplitude_loop_en_reg <=
            haptic_cfg_pkg::RST_TOP_CFG[haptic_cfg_pkg::BIT_AMP_LOOP];
         fault_flag_reg <= 1'b0;
         reg_rdata_reg <= haptic_cfg_pkg::RST_RDATA;
      end
      else if (clk_en)
      begin
         max_current_code_reg <= current_code_next;
         drive_scale_reg <= {scale_high_next, scale_low_next};
         embedded_mode_reg <= embedded_next;
         erm_type_reg <= erm_next;
         loop_compute_en_reg <=
            top_cfg_next[haptic_cfg_pkg::BIT_LOOP_COMPUTE];
         freq_track_active_reg <= track_next;
         accel_en_reg <= top_cfg_next[haptic_cfg_pkg::BIT_ACCEL];
         rapid_stop_en_reg <=
            top_cfg_next[haptic_cfg_pkg::BIT_RAPID_STOP];
         amplitude_loop_en_reg <=
            top_cfg_next[haptic_cfg_pkg::BIT_AMP_LOOP];
         fault_flag_reg <= fault_flag_next;
         if (reg_rd)
         begin
            reg_rdata_reg <= rdata_next;
         end
      end
   end

   // full scale follows the acceleration enable after its own flop
   full_scale_select u_full_scale
   (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .accel_en(accel_en_reg),
      .nominal_rating(nominal_rating),
      .abs_max_rating(abs_max_rating),
      .full_scale_reg(full_scale_reg),
      .overdrive_limit_reg(overdrive_limit_reg)
   );

   // checks
   sequence s_write_top;
      clk_en && reg_wr && sel_top;
   endsequence

   a_current_write_lands: assert property (@(posedge ref_clk)
      disable iff (sys_rst) clk_en && wr_current
      |=> max_current_code_reg == $past(reg_wdata[4:0]))
      else $error("current code not written");

   a_scale_concat: assert property (@(posedge ref_clk)
      disable iff (sys_rst) drive_scale_reg == {scale_high_reg,
      scale_low_reg})
      else $error("scale factor bytes misplaced");

   a_imp_readback: assert property (@(posedge ref_clk)
      disable iff (sys_rst) clk_en && reg_rd && sel_imp_l
      |=> reg_rdata_reg == {6'h00, $past(impedance_reg[1:0])})
      else $error("impedance low byte read wrong");

   a_imp_readonly: assert property (@(posedge ref_clk)
      disable iff (sys_rst) clk_en && !imp_load
      |=> impedance_reg == $past(impedance_reg))
      else $error("impedance changed without a measurement");

   a_fault_sticky: assert property (@(posedge ref_clk)
      disable iff (sys_rst) clk_en && fault_flag_reg && !fault_clear
      && !embedded_next |=> fault_flag_reg)
      else $error("fault flag dropped without clear");

   a_fault_auto_clear: assert property (@(posedge ref_clk)
      disable iff (sys_rst) clk_en && embedded_next && !fault_event
      |=> !fault_flag_reg)
      else $error("embedded mode did not clear fault");

   a_fault_set_wins: assert property (@(posedge ref_clk)
      disable iff (sys_rst) clk_en && fault_event |=> fault_flag_reg)
      else $error("fault event lost");

   a_top_fields: assert property (
      @(posedge ref_clk)
      disable iff (sys_rst) s_write_top |=> erm_type_reg ==
      $past(reg_wdata[5]) && loop_compute_en_reg == $past(reg_wdata[4])
      && accel_en_reg == $past(reg_wdata[2]) && rapid_stop_en_reg ==
      $past(reg_wdata[1]) && amplitude_loop_en_reg ==
      $past(reg_wdata[0]))
      else $error("configuration field not applied");

   a_track_gated: assert property (@(posedge ref_clk)
      disable iff (sys_rst) erm_type_reg |-> !freq_track_active_reg)
      else $error("tracking active with rotating actuator");

   // the flop holds what was sampled one edge earlier, so the
   // expectation is built from the previous cycle's inputs
   a_full_scale_pick: assert property (@(posedge ref_clk)
      disable iff (sys_rst) clk_en && $stable(nominal_rating)
      && $stable(abs_max_rating) && $stable(accel_en_reg)
      |=> full_scale_reg == ($past(accel_en_reg) ? $past(nominal_rating)
      : $past(abs_max_rating)))
      else $error("full scale from wrong rating");

   a_unused_zero: assert property (@(posedge ref_clk)
      disable iff (sys_rst) top_cfg_reg[6] == 1'b0
      && current_code_reg == max_current_code_reg)
      else $error("unused bit set or current copy stale");
endmodule : haptic_actuator_calib_config_regs

// [testbench/host_port_model.sv]
// host model driving the byte register port of the haptic bank
`timescale 1ns/1ps
module host_port_model
(
   input wire logic ref_clk, // register clock
   output logic [7:0] reg_addr, // address to the bank
   output logic reg_wr, // write strobe
   output logic [7:0] reg_wdata, // write data
   output logic reg_rd, // read strobe
   input wire logic [7:0] reg_rdata_reg // registered read data
);
   // idle port at time zero
   initial
   begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_wdata = 8'h00;
      reg_rd = 1'b0;
   end
   // one-cycle write; scale bytes come as the host worked them out
   task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge ref_clk);
      reg_wr = 1'b0;
      // released lines change, so a stale value cannot pass for data
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask : write_byte
   // one-cycle read; data is registered one cycle after the strobe
   task automatic read_byte(input logic [7:0] a, output logic [7:0] d);
      @(negedge ref_clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge ref_clk);
      reg_rd = 1'b0;
      d = reg_rdata_reg;
      reg_addr = ~a;
   endtask : read_byte
endmodule : host_port_model

// [testbench/haptic_actuator_calib_config_regs_tb_top.sv]
// self-checking bench for the haptic calibration register bank
`timescale 1ns/1ps
module haptic_actuator_calib_config_regs_tb_top;
   logic ref_clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1; // clock and control
   logic imp_load = 1'b0, fault_event = 1'b0, fault_clear = 1'b0; // events
   logic [9:0] imp_value = 10'h000, imp; // measured impedance
   logic [7:0] nominal_rating = 8'h5A, abs_max_rating = 8'h78; // ratings
   logic [7:0] reg_addr, reg_wdata, reg_rdata_reg, rd, d; // register port
   logic reg_wr, reg_rd; // strobes
   logic [4:0] max_current_code_reg; // current code
   logic [15:0] drive_scale_reg; // scale factor
   logic [7:0] full_scale_reg, overdrive_limit_reg; // selected ratings
   logic embedded_mode_reg, erm_type_reg, loop_compute_en_reg; // cfg bits
   logic freq_track_active_reg, accel_en_reg, rapid_stop_en_reg; // cfg bits
   logic amplitude_loop_en_reg, fault_flag_reg; // cfg bit and fault
   logic [7:0] shadow [4]; // expected contents of the writable bytes
   logic [15:0] v; // scale factor worked out by the host
   int n_errors = 0, comparisons = 0, n, k; // counters and indices
   // top byte as seen on the outputs, bit 6 always zero
   wire logic [7:0] top_bits = {embedded_mode_reg, 1'b0, erm_type_reg,
      loop_compute_en_reg, freq_track_active_reg, accel_en_reg,
      rapid_stop_en_reg, amplitude_loop_en_reg};

   // 10 MHz clock
   always #50 ref_clk = ~ref_clk;

   host_port_model host (.ref_clk(ref_clk), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
      .reg_rdata_reg(reg_rdata_reg));
   haptic_actuator_calib_config_regs DUT (.ref_clk(ref_clk),
      .sys_rst(sys_rst), .clk_en(clk_en), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
      .reg_rdata_reg(reg_rdata_reg), .imp_load(imp_load),
      .imp_value(imp_value), .fault_event(fault_event),
      .fault_clear(fault_clear), .nominal_rating(nominal_rating),
      .abs_max_rating(abs_max_rating),
      .max_current_code_reg(max_current_code_reg),
      .drive_scale_reg(drive_scale_reg),
      .embedded_mode_reg(embedded_mode_reg), .erm_type_reg(erm_type_reg),
      .loop_compute_en_reg(loop_compute_en_reg),
      .freq_track_active_reg(freq_track_active_reg),
      .accel_en_reg(accel_en_reg), .rapid_stop_en_reg(rapid_stop_en_reg),
      .amplitude_loop_en_reg(amplitude_loop_en_reg),
      .fault_flag_reg(fault_flag_reg), .full_scale_reg(full_scale_reg),
      .overdrive_limit_reg(overdrive_limit_reg));

   // address of writable byte k
   function automatic logic [7:0] addr_of(input int k);
      return (k == 3) ? 8'h13 : 8'h0E + 8'(k);
   endfunction : addr_of
   // implemented bits of writable byte k
   function automatic logic [7:0] wmask(input int k);
      return (k == 0) ? 8'h1F : (k == 3) ? 8'hBF : 8'hFF;
   endfunction : wmask
   // outputs expected from a top byte; tracking is off for rotating type
   function automatic logic [7:0] exp_top(input logic [7:0] s);
      return {s[7], 1'b0, s[5:4], s[3] & ~s[5], s[2:0]};
   endfunction : exp_top
   // reset contents of 0x0E..0x13
   function automatic logic [7:0] rst_val(input int k);
      case (k)
         0: return 8'h17;
         1: return 8'h01;
         2: return 8'h0D;
         5: return 8'h1E;
         default: return 8'h00;
      endcase
   endfunction : rst_val
   // scale the host programs for z ohms at current code c
   function automatic logic [15:0] scale_for(input real z,
      input logic [4:0] c);
      return 16'($rtoi(z * (real'(c) + haptic_cfg_pkg::SCALE_CODE_OFFSET)
         / haptic_cfg_pkg::SCALE_DIVISOR));
   endfunction : scale_for

   // one comparison, counted
   task automatic check(input string name, input logic [15:0] seen,
      input logic [15:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // counts, verdict and end of run
   task automatic results();
      $display("comparisons %0d errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : results

   // watchdog: a hang counts as a mismatch
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      n_errors++;
      results();
   end

   // main sequence
   initial
   begin
      void'($urandom(70));
      repeat (5) @(posedge ref_clk);
      @(negedge ref_clk) sys_rst = 1'b0;
      // reset contents of every byte
      for (k = 0; k < 6; k++)
      begin
         host.read_byte(8'h0E + 8'(k), rd);
         check("reset byte", rd, rst_val(k));
      end
      check("reset top", top_bits, 8'h1E);
      check("reset scale", drive_scale_reg, 16'h010D);
      check("reset full scale", full_scale_reg, nominal_rating);
      for (k = 0; k < 4; k++) shadow[k] = rst_val(k == 3 ? 5 : k);
      // all-zero and all-one corners first, then random bytes
      for (n = 0; n < 40; n++)
      begin
         k = n % 4;
         d = (n < 8) ? {8{n[2]}} : 8'($urandom);
         nominal_rating = 8'($urandom);
         abs_max_rating = 8'($urandom);
         host.write_byte(addr_of(k), d);
         shadow[k] = d & wmask(k);
         host.read_byte(addr_of(k), rd);
         check("readback", rd, shadow[k]);
         check("code", max_current_code_reg, shadow[0][4:0]);
         check("scale", drive_scale_reg, {shadow[1], shadow[2]});
         check("top", top_bits, exp_top(shadow[3]));
         check("full scale", full_scale_reg,
            shadow[3][2] ? nominal_rating : abs_max_rating);
         check("overdrive", overdrive_limit_reg, abs_max_rating);
      end
      // host works out the scale from impedance and the current code
      v = scale_for(real'($urandom_range(40, 4)), shadow[0][4:0]);
      host.write_byte(8'h0F, v[15:8]);
      host.write_byte(8'h10, v[7:0]);
      check("host scale", drive_scale_reg, v);
      // read-only impedance ignores writes; all-ones corner first
      for (n = 0; n < 3; n++)
      begin
         imp = (n == 0) ? 10'h3FF : 10'($urandom);
         @(negedge ref_clk);
         imp_value = imp;
         imp_load = 1'b1;
         @(negedge ref_clk);
         imp_load = 1'b0;
         imp_value = ~imp;
         host.write_byte(8'h11, ~imp[9:2]);
         host.read_byte(8'h11, rd);
         check("impedance high", rd, imp[9:2]);
         host.read_byte(8'h12, rd);
         check("impedance low", rd, {6'h00, imp[1:0]});
      end
      host.write_byte(8'h21, 8'hA5);
      host.read_byte(8'h21, rd);
      check("unmapped", rd, 8'h00);
      // faults held for the host, then cleared by the device itself
      host.write_byte(8'h13, 8'h1E);
      @(negedge ref_clk) fault_event = 1'b1;
      @(negedge ref_clk) fault_event = 1'b0;
      repeat (3) @(negedge ref_clk);
      check("fault held", fault_flag_reg, 1'b1);
      fault_clear = 1'b1;
      @(negedge ref_clk) fault_clear = 1'b0;
      check("fault host clear", fault_flag_reg, 1'b0);
      host.write_byte(8'h13, 8'h9E);
      @(negedge ref_clk) fault_event = 1'b1;
      @(negedge ref_clk) fault_event = 1'b0;
      check("fault auto set", fault_flag_reg, 1'b1);
      @(negedge ref_clk);
      check("fault auto clear", fault_flag_reg, 1'b0);
      // a write while frozen is lost
      @(negedge ref_clk) clk_en = 1'b0;
      host.write_byte(8'h13, 8'h00);
      clk_en = 1'b1;
      host.read_byte(8'h13, rd);
      check("frozen write", rd, 8'h9E);
      // second reset in mid-run restores the top byte
      @(negedge ref_clk) sys_rst = 1'b1;
      @(negedge ref_clk) sys_rst = 1'b0;
      host.read_byte(8'h13, rd);
      check("rereset top", rd, 8'h1E);
      results();
   end
endmodule : haptic_actuator_calib_config_regs_tb_top
